// *** testbench/flash_block_code_protection_bench.sv ***
// bench: table, programmer, erase and pin scenarios for flash protection
`timescale 1ns/1ns
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", n, e, v); end end
module flash_block_code_protection_bench;
    import flash_protect_pkg::*;
    logic        core_clk, rstn, hv_vpp, hv_lvl, pm_pin, ee_sel;
    access_req_t table_req, cpu_ee_req, prog_req;
    logic [21:0] exec_addr;
    logic [7:0]  table_mem_rdata, prog_mem_rdata, table_latch_r, prog_rdata_r;
    logic        ch_er, rg_er, table_mem_wr_r, table_done_r, cpu_ee_grant_r;
    logic        prog_mem_wr_r, prog_done_r, gpio_en, pullup_en, dbg_en;
    logic [2:0]  er_reg;
    logic [1:0]  prog_mode_r;
    int          err_count, checks_done;

    flash_block_code_protection u_flash_block_code_protection (
        .core_clk(core_clk), .rstn(rstn), .table_req(table_req),
        .exec_addr(exec_addr), .table_mem_rdata(table_mem_rdata),
        .table_mem_wr_r(table_mem_wr_r), .table_latch_r(table_latch_r),
        .table_done_r(table_done_r), .cpu_ee_req(cpu_ee_req),
        .cpu_ee_grant_r(cpu_ee_grant_r), .master_clear_vpp_pin(hv_vpp),
        .high_voltage_entry_level(hv_lvl), .program_mode_pin(pm_pin),
        .prog_req(prog_req), .prog_eeprom_sel(ee_sel),
        .prog_chip_erase(ch_er), .prog_region_erase(rg_er),
        .prog_erase_region(er_reg), .prog_mem_rdata(prog_mem_rdata),
        .prog_mem_wr_r(prog_mem_wr_r), .prog_rdata_r(prog_rdata_r),
        .prog_done_r(prog_done_r), .prog_mode_r(prog_mode_r),
        .pgm_pin_gpio_en_r(gpio_en), .pgm_pin_pullup_en_r(pullup_en),
        .debugger_enable_r(dbg_en));
    flash_mem_model u_flash_mem_model (
        .core_clk(core_clk), .t_req(table_req), .t_wr(table_mem_wr_r),
        .t_rdata(table_mem_rdata), .p_req(prog_req), .p_wr(prog_mem_wr_r),
        .p_rdata(prog_mem_rdata));

    // ------------------------------------------------------------------
    // access tasks: request one edge, answer checked in the next cycle
    // ------------------------------------------------------------------
    function automatic logic [7:0] md(input logic [21:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    // reads check latch against d; config and id write permits unchecked
    task automatic tb(input logic w, input logic [21:0] a, x,
                      input logic [7:0] d, input logic ew);
        table_req = '{1'b1, w, a, d};
        exec_addr = x;
        @(posedge core_clk);
        #2 table_req.valid = 1'b0;
        `CHK("table_done", 1'b1, table_done_r)
        if (!w) `CHK("table_latch", d, table_latch_r)
        else if (!a[21]) `CHK("table_wr", ew, table_mem_wr_r)
        @(posedge core_clk);
        #2;
    endtask
    task automatic pg(input logic w, e, input logic [21:0] a,
                      input logic [7:0] d, input logic ew);
        prog_req = '{1'b1, w, a, d};
        ee_sel = e;
        @(posedge core_clk);
        #2 prog_req.valid = 1'b0;
        `CHK("prog_done", 1'b1, prog_done_r)
        if (!w) `CHK("prog_rdata", d, prog_rdata_r)
        else if (!a[21]) `CHK("prog_wr", ew, prog_mem_wr_r)
        @(posedge core_clk);
        #2;
    endtask
    // erases only ever come from the programmer side
    task automatic er(input logic c, input logic [2:0] r);
        ch_er = c;
        rg_er = !c;
        er_reg = r;
        @(posedge core_clk);
        #2 ch_er = 1'b0;
        rg_er = 1'b0;
        repeat (2) @(posedge core_clk);
        #2;
    endtask
    // mode register follows the pins one edge late, so allow two
    task automatic pins(input logic v, h, p);
        hv_vpp = v;
        hv_lvl = h;
        pm_pin = p;
        repeat (2) @(posedge core_clk);
        #2;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and scenarios
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        {table_req, cpu_ee_req, prog_req, exec_addr} = '0;
        {hv_vpp, hv_lvl, pm_pin, ee_sel, ch_er, rg_er, er_reg} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (8) @(posedge core_clk);
        #2 rstn = 1'b1;
        @(posedge core_clk);
        #2 `CHK("pin_ctl", 3'b000, {gpio_en, pullup_en, dbg_en})
        tb(0, 22'h000310, 22'h000000, md(22'h000310), 0);
        tb(1, 22'h30000A, 22'h000000, 8'hFC, 0);
        tb(1, 22'h000300, 22'h000000, md(22'h000300), 0);
        tb(1, 22'h30000A, 22'h000000, 8'hFF, 0);
        tb(1, 22'h0020F0, 22'h000000, md(22'h0020F0), 0);
        tb(1, 22'h0040F0, 22'h000000, md(22'h0040F0), 1);
        tb(1, 22'h0001FF, 22'h000000, md(22'h0001FF), 1);
        tb(1, 22'h000200, 22'h000000, md(22'h000200), 0);
        $display("test table_write done");
        tb(1, 22'h30000C, 22'h000000, 8'hFD, 0);
        tb(0, 22'h002110, 22'h001000, 8'h00, 0);
        tb(0, 22'h002110, 22'h003FFE, md(22'h002110), 0);
        tb(0, 22'h001FFF, 22'h002000, md(22'h001FFF), 0);
        tb(1, 22'h30000D, 22'h000000, 8'hBF, 0);
        tb(0, 22'h0001F0, 22'h000200, 8'h00, 0);
        tb(0, 22'h0001F0, 22'h0001FE, md(22'h0001F0), 0);
        tb(0, 22'h008010, 22'h000000, 8'h00, 0);
        $display("test cross_read done");
        tb(1, 22'h300008, 22'h000000, 8'h00, 0);
        tb(1, 22'h300009, 22'h000000, 8'h3F, 0);
        tb(0, 22'h000310, 22'h000000, md(22'h000310), 0);
        cpu_ee_req = '{1'b1, 1'b1, 22'h000010, 8'h55};
        @(posedge core_clk);
        #2 cpu_ee_req.valid = 1'b0;
        `CHK("ee_grant", 1'b1, cpu_ee_grant_r)
        pins(1, 1, 0);
        `CHK("prog_mode", 2'h2, prog_mode_r)
        pg(0, 0, 22'h000320, 8'h00, 0);
        pg(0, 0, 22'h200003, md(22'h200003), 0);
        pg(0, 1, 22'h000010, 8'h00, 0);
        pg(1, 1, 22'h000010, 8'h12, 0);
        pg(1, 0, 22'h300006, 8'h7B, 0);
        `CHK("pin_ctl", 3'b111, {gpio_en, pullup_en, dbg_en})
        pins(0, 0, 1);
        `CHK("prog_mode", 2'h0, prog_mode_r)
        pins(1, 1, 0);
        er(0, 3'h1);
        tb(1, 22'h0020F0, 22'h000000, md(22'h0020F0), 1);
        er(1, 3'h0);
        tb(1, 22'h000300, 22'h000000, md(22'h000300), 1);
        pins(0, 0, 1);
        `CHK("mode_pins", 4'h4, {prog_mode_r, gpio_en, dbg_en})
        pg(0, 0, 22'h000320, md(22'h000320), 0);
        pg(1, 0, 22'h000320, md(22'h000320), 1);
        pins(0, 0, 0);
        $display("test programmer done");
        give_verdict();
    end
endmodule

bind flash_block_code_protection flash_protect_asserts
    u_flash_protect_asserts (
    .core_clk(core_clk), .rstn(rstn), .table_req(table_req),
    .cpu_ee_req(cpu_ee_req), .table_done_r(table_done_r),
    .table_mem_wr_r(table_mem_wr_r), .table_latch_r(table_latch_r),
    .cpu_ee_grant_r(cpu_ee_grant_r),
    .master_clear_vpp_pin(master_clear_vpp_pin),
    .high_voltage_entry_level(high_voltage_entry_level),
    .program_mode_pin(program_mode_pin), .prog_mode_r(prog_mode_r),
    .pgm_pin_gpio_en_r(pgm_pin_gpio_en_r),
    .pgm_pin_pullup_en_r(pgm_pin_pullup_en_r));

// *** testbench/flash_mem_model.sv ***
// model: flash byte array seen by both table and programmer ports
`timescale 1ns/1ns
module flash_mem_model
    import flash_protect_pkg::*;
(
    input  wire logic        core_clk,
    input  wire access_req_t t_req,
    input  wire logic        t_wr,
    output logic      [7:0]  t_rdata,
    input  wire access_req_t p_req,
    input  wire logic        p_wr,
    output logic      [7:0]  p_rdata
);
    logic [7:0] mem [256];
    // seeded from the address so the bench predicts every byte
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    // low byte index only: aliases are harmless, writes restore the seed
    assign t_rdata = mem[t_req.addr[7:0]];
    assign p_rdata = mem[p_req.addr[7:0]];
    // a byte lands only on the permit pulse while addr/data are held
    always @(posedge core_clk) begin
        if (t_wr) begin
            mem[t_req.addr[7:0]] <= t_req.wdata;
        end
        if (p_wr) begin
            mem[p_req.addr[7:0]] <= p_req.wdata;
        end
    end
endmodule

// *** testbench/flash_protect_asserts.sv ***
// checker: port-level timing and gating properties of flash protection
`timescale 1ns/1ns
module flash_protect_asserts
    import flash_protect_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire access_req_t table_req,
    input wire access_req_t cpu_ee_req,
    input wire logic        table_done_r,
    input wire logic        table_mem_wr_r,
    input wire logic [7:0]  table_latch_r,
    input wire logic        cpu_ee_grant_r,
    input wire logic        master_clear_vpp_pin,
    input wire logic        high_voltage_entry_level,
    input wire logic        program_mode_pin,
    input wire logic [1:0]  prog_mode_r,
    input wire logic        pgm_pin_gpio_en_r,
    input wire logic        pgm_pin_pullup_en_r
);
    // ------------------------------------------------------------------
    // properties, all on the core clock
    // ------------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_done_after_req: assert property (
        table_req.valid |=> table_done_r)
        else $error("table done missing after request");
    a_done_has_cause: assert property (
        table_done_r |-> $past(table_req.valid))
        else $error("table done without request");
    a_ee_always_granted: assert property (
        cpu_ee_req.valid |=> cpu_ee_grant_r)
        else $error("processor eeprom access not granted");
    a_wr_needs_write: assert property (table_mem_wr_r |->
        $past(table_req.valid && table_req.write))
        else $error("write permit without table write");
    // absent space must never leak flash data into the latch
    a_unimpl_reads_zero: assert property (table_req.valid
        && !table_req.write && table_req.addr >= USER_MEM_END
        && table_req.addr < USER_ID_BASE |=> table_latch_r == 8'h00)
        else $error("unimplemented space read nonzero");
    a_hv_entry_wins: assert property (master_clear_vpp_pin
        && high_voltage_entry_level |=> prog_mode_r == 2'h2)
        else $error("high voltage entry refused");
    a_lv_needs_pin: assert property (
        prog_mode_r == 2'h1 |-> $past(program_mode_pin))
        else $error("low voltage mode without pin");
    a_pullup_gpio_pair: assert property (
        pgm_pin_pullup_en_r == pgm_pin_gpio_en_r)
        else $error("pull-up and gpio enable disagree");
endmodule

// *** verilog/flash_block_code_protection.sv ***
// flash_block_code_protection: gates table and programmer memory accesses
`timescale 1ns/1ns
module flash_block_code_protection
    import flash_protect_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // processor table access
    input  wire access_req_t table_req,
    input  wire logic [21:0] exec_addr,
    input  wire logic [7:0]  table_mem_rdata,
    output logic             table_mem_wr_r,
    output logic      [7:0]  table_latch_r,
    output logic             table_done_r,
    // processor eeprom access
    input  wire access_req_t cpu_ee_req,
    output logic             cpu_ee_grant_r,
    // external programmer
    input  wire logic        master_clear_vpp_pin,
    input  wire logic        high_voltage_entry_level,
    input  wire logic        program_mode_pin,
    input  wire access_req_t prog_req,
    input  wire logic        prog_eeprom_sel,
    input  wire logic        prog_chip_erase,
    input  wire logic        prog_region_erase,
    input  wire logic [2:0]  prog_erase_region,
    input  wire logic [7:0]  prog_mem_rdata,
    output logic             prog_mem_wr_r,
    output logic      [7:0]  prog_rdata_r,
    output logic             prog_done_r,
    output logic      [1:0]  prog_mode_r,
    // pin and debug control
    output logic             pgm_pin_gpio_en_r,
    output logic             pgm_pin_pullup_en_r,
    output logic             debugger_enable_r
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        protect_bits_t pb;
        prog_mode_t    mode;
        logic          tbl_wr;
        logic [7:0]    tbl_lat;
        logic          tbl_done;
        logic          ee_grant;
        logic          prg_wr;
        logic [7:0]    prg_rdata;
        logic          prg_done;
        logic          gpio_en;
        logic          pullup_en;
        logic          dbg_en;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [2:0] ptr_region;
    logic [2:0] exec_region;
    logic [2:0] prg_region;

    // ------------------------------------------------------------------
    // region decoders
    // ------------------------------------------------------------------
    region_decode #(.LARGE_PART(LARGE_PART)) u_ptr_dec (
        .addr   (table_req.addr),
        .region (ptr_region)
    );
    region_decode #(.LARGE_PART(LARGE_PART)) u_exec_dec (
        .addr   (exec_addr),
        .region (exec_region)
    );
    region_decode #(.LARGE_PART(LARGE_PART)) u_prog_dec (
        .addr   (prog_req.addr),
        .region (prg_region)
    );

    // ------------------------------------------------------------------
    // config byte image and update helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] cfg_read(input protect_bits_t p,
                                            input logic [21:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            REGION_READOUT_PROTECT_LOW_ADDR:   v[3:0] = p.readout[3:0];
            BOOT_EEPROM_READOUT_PROTECT_ADDR: begin
                v[EEPROM_BIT_POS] = p.eeprom_readout;
                v[BOOT_BIT_POS]   = p.readout[4];
            end
            REGION_WRITE_PROTECT_LOW_ADDR:     v[3:0] = p.write[3:0];
            BOOT_EEPROM_CONFIG_WRITE_PROTECT_ADDR: begin
                v[EEPROM_BIT_POS]    = p.eeprom_write;
                v[BOOT_BIT_POS]      = p.write[4];
                v[CONFIG_WP_BIT_POS] = p.config_write;
            end
            REGION_TABLEREAD_PROTECT_LOW_ADDR: v[3:0] = p.cross_read[3:0];
            BOOT_TABLEREAD_PROTECT_ADDR:       v[BOOT_BIT_POS] = p.cross_read[4];
            DEBUG_LOWVOLT_CONFIG_BYTE_ADDR: begin
                v[DEBUG_BIT_POS]   = p.debug_n;
                v[LOWVOLT_BIT_POS] = p.lowvolt;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // programming ANDs the new byte in, so bits only ever fall to zero
    function automatic protect_bits_t cfg_write(input protect_bits_t p,
                                                input logic [21:0] a,
                                                input logic [7:0] d,
                                                input logic lv_ok,
                                                input logic cw_ok);
        protect_bits_t q;
        q = p;
        case (a)
            REGION_READOUT_PROTECT_LOW_ADDR:
                q.readout[3:0] = p.readout[3:0] & d[3:0];
            BOOT_EEPROM_READOUT_PROTECT_ADDR: begin
                q.eeprom_readout = p.eeprom_readout & d[EEPROM_BIT_POS];
                q.readout[4]     = p.readout[4] & d[BOOT_BIT_POS];
            end
            REGION_WRITE_PROTECT_LOW_ADDR:
                q.write[3:0] = p.write[3:0] & d[3:0];
            BOOT_EEPROM_CONFIG_WRITE_PROTECT_ADDR: begin
                q.eeprom_write = p.eeprom_write & d[EEPROM_BIT_POS];
                q.write[4]     = p.write[4] & d[BOOT_BIT_POS];
                if (cw_ok) begin
                    q.config_write = p.config_write &
                                     d[CONFIG_WP_BIT_POS];
                end
            end
            REGION_TABLEREAD_PROTECT_LOW_ADDR:
                q.cross_read[3:0] = p.cross_read[3:0] & d[3:0];
            BOOT_TABLEREAD_PROTECT_ADDR:
                q.cross_read[4] = p.cross_read[4] & d[BOOT_BIT_POS];
            DEBUG_LOWVOLT_CONFIG_BYTE_ADDR: begin
                q.debug_n = p.debug_n & d[DEBUG_BIT_POS];
                if (lv_ok) begin
                    q.lowvolt = p.lowvolt & d[LOWVOLT_BIT_POS];
                end
            end
            default: q = p;
        endcase
        return q;
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic is_cfg_t;
        logic is_id_t;
        logic is_cfg_p;
        logic is_id_p;
        logic prog_on;
        logic hv_entry;
        logic lv_entry;
        is_cfg_t = (table_req.addr >= CONFIG_BASE) &&
                   (table_req.addr <= CONFIG_LAST);
        is_id_t  = (table_req.addr >= USER_ID_BASE) &&
                   (table_req.addr <= USER_ID_LAST);
        is_cfg_p = (prog_req.addr >= CONFIG_BASE) &&
                   (prog_req.addr <= CONFIG_LAST);
        is_id_p  = (prog_req.addr >= USER_ID_BASE) &&
                   (prog_req.addr <= USER_ID_LAST);
        hv_entry = master_clear_vpp_pin && high_voltage_entry_level;
        lv_entry = program_mode_pin && st_r.pb.lowvolt;
        prog_on  = (st_r.mode != PROG_IDLE);
        st_nxt = st_r;
        st_nxt.tbl_wr   = 1'b0;
        st_nxt.tbl_done = 1'b0;
        st_nxt.ee_grant = 1'b0;
        st_nxt.prg_wr   = 1'b0;
        st_nxt.prg_done = 1'b0;

        // programming entry: high voltage always wins over low voltage
        if (hv_entry) begin
            st_nxt.mode = PROG_HIGHVOLT;
        end else if (lv_entry) begin
            st_nxt.mode = PROG_LOWVOLT;
        end else begin
            st_nxt.mode = PROG_IDLE;
        end

        // processor table access, gated on pointer and executing region
        if (table_req.valid) begin
            st_nxt.tbl_done = 1'b1;
            if (table_req.write) begin
                if (is_cfg_t) begin
                    if (st_r.pb.config_write) begin
                        st_nxt.pb = cfg_write(st_r.pb, table_req.addr,
                                              table_req.wdata, 1'b0, 1'b0);
                    end
                end else if (is_id_t) begin
                    st_nxt.tbl_wr = 1'b1;
                end else if (ptr_region != REGION_NONE) begin
                    st_nxt.tbl_wr = st_r.pb.write[ptr_region];
                end
            end else begin
                if (is_cfg_t) begin
                    st_nxt.tbl_lat = cfg_read(st_r.pb, table_req.addr);
                end else if (is_id_t) begin
                    st_nxt.tbl_lat = table_mem_rdata;
                end else if (ptr_region == REGION_NONE) begin
                    st_nxt.tbl_lat = 8'h00;
                end else if (!st_r.pb.cross_read[ptr_region] &&
                             ptr_region != exec_region) begin
                    st_nxt.tbl_lat = 8'h00;
                end else begin
                    st_nxt.tbl_lat = table_mem_rdata;
                end
            end
        end

        // processor eeprom access is never gated by protection bits
        st_nxt.ee_grant = cpu_ee_req.valid;

        // external programmer: erases, config, ids, memory, eeprom
        if (prog_on) begin
            if (prog_chip_erase) begin
                st_nxt.pb.readout        = {BIT_ERASED, REGION_ERASED};
                st_nxt.pb.write          = {BIT_ERASED, REGION_ERASED};
                st_nxt.pb.cross_read     = {BIT_ERASED, REGION_ERASED};
                st_nxt.pb.eeprom_readout = BIT_ERASED;
                st_nxt.pb.eeprom_write   = BIT_ERASED;
                st_nxt.pb.config_write   = BIT_ERASED;
                st_nxt.pb.debug_n        = BIT_ERASED;
                st_nxt.pb.lowvolt        = BIT_ERASED;
                st_nxt.prg_done          = 1'b1;
            end else if (prog_region_erase &&
                         prog_erase_region <= REGION_BOOT) begin
                st_nxt.pb.readout[prog_erase_region]    = BIT_ERASED;
                st_nxt.pb.write[prog_erase_region]      = BIT_ERASED;
                st_nxt.pb.cross_read[prog_erase_region] = BIT_ERASED;
                st_nxt.prg_done = 1'b1;
            end else if (prog_req.valid) begin
                st_nxt.prg_done = 1'b1;
                if (prog_eeprom_sel) begin
                    if (prog_req.write) begin
                        st_nxt.prg_wr = st_r.pb.eeprom_readout &&
                                        st_r.pb.eeprom_write;
                    end else begin
                        st_nxt.prg_rdata = st_r.pb.eeprom_readout ?
                                           prog_mem_rdata : 8'h00;
                    end
                end else if (is_cfg_p) begin
                    if (prog_req.write) begin
                        st_nxt.pb = cfg_write(st_r.pb, prog_req.addr,
                                              prog_req.wdata,
                                              st_r.mode == PROG_HIGHVOLT,
                                              1'b1);
                    end else begin
                        st_nxt.prg_rdata = cfg_read(st_r.pb, prog_req.addr);
                    end
                end else if (is_id_p) begin
                    if (prog_req.write) begin
                        st_nxt.prg_wr = 1'b1;
                    end else begin
                        st_nxt.prg_rdata = prog_mem_rdata;
                    end
                end else if (prg_region == REGION_NONE) begin
                    st_nxt.prg_rdata = 8'h00;
                end else if (prog_req.write) begin
                    st_nxt.prg_wr = st_r.pb.readout[prg_region] &&
                                    st_r.pb.write[prg_region];
                end else begin
                    st_nxt.prg_rdata = st_r.pb.readout[prg_region] ?
                                       prog_mem_rdata : 8'h00;
                end
            end
        end

        // pin ownership and debugger follow the live configuration bits
        st_nxt.gpio_en   = !st_nxt.pb.lowvolt;
        st_nxt.pullup_en = !st_nxt.pb.lowvolt;
        st_nxt.dbg_en    = !st_nxt.pb.debug_n;
    end

    // ------------------------------------------------------------------
    // state register; erased part comes up with all bits at one
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r.pb        <= '1;
            st_r.mode      <= PROG_IDLE;
            st_r.tbl_wr    <= 1'b0;
            st_r.tbl_lat   <= 8'h00;
            st_r.tbl_done  <= 1'b0;
            st_r.ee_grant  <= 1'b0;
            st_r.prg_wr    <= 1'b0;
            st_r.prg_rdata <= 8'h00;
            st_r.prg_done  <= 1'b0;
            st_r.gpio_en   <= 1'b0;
            st_r.pullup_en <= 1'b0;
            st_r.dbg_en    <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from the state flops
    // ------------------------------------------------------------------
    assign table_mem_wr_r      = st_r.tbl_wr;
    assign table_latch_r       = st_r.tbl_lat;
    assign table_done_r        = st_r.tbl_done;
    assign cpu_ee_grant_r      = st_r.ee_grant;
    assign prog_mem_wr_r       = st_r.prg_wr;
    assign prog_rdata_r        = st_r.prg_rdata;
    assign prog_done_r         = st_r.prg_done;
    assign prog_mode_r         = st_r.mode;
    assign pgm_pin_gpio_en_r   = st_r.gpio_en;
    assign pgm_pin_pullup_en_r = st_r.pullup_en;
    assign debugger_enable_r   = st_r.dbg_en;

endmodule

// *** verilog/flash_protect_pkg.sv ***
// package: address map, config byte layout and types for flash protection
package flash_protect_pkg;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam logic [21:0] BOOT_SIZE_BYTES   = 22'h000200;
    localparam logic [21:0] BLOCK0_BASE       = 22'h000200;
    localparam logic [21:0] BLOCK1_BASE       = 22'h002000;
    localparam logic [21:0] BLOCK2_BASE       = 22'h004000;
    localparam logic [21:0] BLOCK3_BASE       = 22'h006000;
    localparam logic [21:0] USER_MEM_END      = 22'h008000;
    localparam logic [21:0] SMALL_MEM_END     = 22'h004000;
    localparam logic [21:0] USER_ID_BASE      = 22'h200000;
    localparam logic [21:0] USER_ID_LAST      = 22'h200007;
    localparam logic [21:0] CONFIG_BASE       = 22'h300000;
    localparam logic [21:0] CONFIG_LAST       = 22'h3000FF;

    // ------------------------------------------------------------------
    // protection configuration byte addresses
    // ------------------------------------------------------------------
    localparam logic [21:0] REGION_READOUT_PROTECT_LOW_ADDR     = 22'h300008;
    localparam logic [21:0] BOOT_EEPROM_READOUT_PROTECT_ADDR    = 22'h300009;
    localparam logic [21:0] REGION_WRITE_PROTECT_LOW_ADDR       = 22'h30000A;
    localparam logic [21:0] BOOT_EEPROM_CONFIG_WRITE_PROTECT_ADDR = 22'h30000B;
    localparam logic [21:0] REGION_TABLEREAD_PROTECT_LOW_ADDR   = 22'h30000C;
    localparam logic [21:0] BOOT_TABLEREAD_PROTECT_ADDR         = 22'h30000D;
    localparam logic [21:0] DEBUG_LOWVOLT_CONFIG_BYTE_ADDR      = 22'h300006;

    // ------------------------------------------------------------------
    // field positions and erased values
    // ------------------------------------------------------------------
    localparam int         EEPROM_BIT_POS    = 7;
    localparam int         BOOT_BIT_POS      = 6;
    localparam int         CONFIG_WP_BIT_POS = 5;
    localparam int         DEBUG_BIT_POS     = 7;
    localparam int         LOWVOLT_BIT_POS   = 2;
    localparam logic [3:0] REGION_ERASED     = 4'hF;
    localparam logic       BIT_ERASED        = 1'b1;

    // region numbers: 0..3 ordinary blocks, 4 boot, 5 none
    localparam logic [2:0] REGION_BOOT = 3'h4;
    localparam logic [2:0] REGION_NONE = 3'h5;

    typedef enum logic [1:0] {
        PROG_IDLE,
        PROG_LOWVOLT,
        PROG_HIGHVOLT
    } prog_mode_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [21:0] addr;
        logic [7:0] wdata;
    } access_req_t;

    typedef struct packed {
        logic [4:0] readout;    // bit 4 boot
        logic [4:0] write;
        logic [4:0] cross_read;
        logic       eeprom_readout;
        logic       eeprom_write;
        logic       config_write;
        logic       debug_n;
        logic       lowvolt;
    } protect_bits_t;

endpackage

// *** verilog/region_decode.sv ***
// region_decode: maps a program address onto its protection region number
`timescale 1ns/1ns
module region_decode
    import flash_protect_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
) (
    input  wire logic [21:0] addr,
    output logic      [2:0]  region
);

    // boot first, then four binary blocks; past the part's end is none
    always_comb begin
        if (addr < BOOT_SIZE_BYTES) begin
            region = REGION_BOOT;
        end else if (addr < BLOCK1_BASE) begin
            region = 3'h0;
        end else if (addr < BLOCK2_BASE) begin
            region = 3'h1;
        end else if (LARGE_PART && addr < BLOCK3_BASE) begin
            region = 3'h2;
        end else if (LARGE_PART && addr < USER_MEM_END) begin
            region = 3'h3;
        end else begin
            region = REGION_NONE;
        end
    end

endmodule
